// ==== design/fsne_defines.vh ====
// Constants for the frame sequence number engine: register map, fields, reset values.
// Assumes inclusion by the single design file of the engine.
`ifndef FSNE_DEFINES_VH
`define FSNE_DEFINES_VH

// Register byte addresses
`define FSNE_REG_CFG 6'h00
`define FSNE_REG_TX_SEQ 6'h04
`define FSNE_REG_LAST_RX 6'h08
`define FSNE_REG_RX_CNT 6'h0c
`define FSNE_REG_ERR_CNT 6'h10
`define FSNE_REG_STICKY 6'h14

// Configuration register fields
`define FSNE_CFG_INIT 0
`define FSNE_CFG_RESP 1
`define FSNE_CFG_CHKFIX 2
`define FSNE_CFG_ERRSEL 3
`define FSNE_CFG_ERREXT 4
`define FSNE_CFG_NXTEXT 5
`define FSNE_CFG_COPY 6
`define FSNE_CFG_LOOP 7
`define FSNE_CFG_QU_LSB 8
`define FSNE_CFG_OFF_LSB 16
`define FSNE_CFG_RESET 32'h0000_0000

// Sticky register fields
`define FSNE_STK_RX 0
`define FSNE_STK_ERR 1

// Sequence record layout, byte index from record start
`define FSNE_REC_SEQ_LAST 3'd3
`define FSNE_REC_FLAG 3'd4
`define FSNE_REC_CHK_HI 3'd6
`define FSNE_REC_CHK_LO 3'd7
`define FSNE_REC_LEN 17'd8
`define FSNE_FLAG_BIT 8'h80

// Frame class code of sequence test frames
`define FSNE_CLASS_SEQ 4'h5

// Bus responses
`define FSNE_RESP_OKAY 2'b00
`define FSNE_RESP_SLVERR 2'b10

`endif

// ==== design/fsne_engine.v ====
// Frame sequence number engine: byte stream numbering/checking with an AXI4-Lite register file.
// Assumes frame sideband (direction, class, mac check) stays steady while a frame passes,
// and all inputs come from logic on core_clk_i.
// Function
// - Initiator inserts tx counter, then increments it
// - Record found at programmed 16-bit payload offset
// - Record: number, error flag, reserved, compensation
// - Compensation rewritten on change when fixing enabled
// - Valid means sequence class plus mac pass
// - Tx processing regardless of injection point
// - Disabled engine passes frames like data
// - Initiator role when its enable is one
// - Valid reply sets sticky, bumps reply count
// - Compare with last plus one, then store
// - Mismatch counts error and sets sticky, both per select
// - Optionally extract replies carrying sequence errors
// - Next-reply control extracts one reply only
// - Copy enable copies all replies to queue
// - Responder flags mismatched requests in frame
// - Responder loops, extracts, or both per setting
// - Request or reply from role and direction
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`include "fsne_defines.vh"
`default_nettype none

module fsne_engine #(
  parameter CLASS_W = 4,
  parameter QU_W = 3
) (
  // Clock and reset
  input wire core_clk_i,
  input wire srst_i,
  // AXI4-Lite slave
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Frame sideband, steady for the whole frame
  input wire frm_tx_i,
  input wire [CLASS_W-1:0] frm_class_i,
  input wire frm_dmac_ok_i,
  // Incoming byte stream
  input wire [7:0] in_data_i,
  input wire in_pay_start_i,
  input wire in_last_i,
  input wire in_valid_i,
  output wire in_ready_o,
  // Outgoing byte stream
  output wire [7:0] out_data_o,
  output wire out_last_o,
  output wire out_valid_o,
  input wire out_ready_i,
  // Per-frame verdict, valid while res_valid_o pulses for one cycle after the last byte
  output reg res_valid_o,
  output reg res_extract_o,
  output reg res_loop_o,
  output reg res_seq_err_o,
  output reg [QU_W-1:0] res_queue_o
);

  // Ones-complement 16-bit addition
  function [15:0] oc_add;
    input [15:0] a;
    input [15:0] b;
    reg [16:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      oc_add = s[15:0] + {15'h0000, s[16]};
    end
  endfunction

  // Byte-strobe merge for register writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] st;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (st[i]) begin
          merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  reg [31:0] cfg_q;
  reg [31:0] tx_seq_counter_q;
  reg [31:0] last_rx_seq_q;
  reg [31:0] rx_reply_count_q;
  reg [31:0] rx_seq_error_count_q;
  reg seq_rx_sticky_q;
  reg seq_error_sticky_q;
  reg [5:0] awaddr_q;
  reg aw_full_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_full_q;
  reg [15:0] pos_q;
  reg pay_q;
  reg [23:0] acc_q;
  reg [47:0] rec_old_q;
  reg [47:0] rec_new_q;
  reg err_q;
  reg mod_q;
  reg hold_q;
  reg [7:0] st_data_q;
  reg st_last_q;
  reg st_valid_q;
  reg [7:0] pnd_data_q;
  reg pnd_last_q;
  reg pnd_valid_q;

  wire initiator_role_enable = cfg_q[`FSNE_CFG_INIT];
  wire responder_role_enable = cfg_q[`FSNE_CFG_RESP];
  wire checksum_fix_enable = cfg_q[`FSNE_CFG_CHKFIX];
  wire rx_error_count_select = cfg_q[`FSNE_CFG_ERRSEL];
  wire seq_error_extract_enable = cfg_q[`FSNE_CFG_ERREXT];
  wire next_reply_extract = cfg_q[`FSNE_CFG_NXTEXT];
  wire reply_copy_enable = cfg_q[`FSNE_CFG_COPY];
  wire loop_enable = cfg_q[`FSNE_CFG_LOOP];
  wire [QU_W-1:0] reply_cpu_queue = cfg_q[`FSNE_CFG_QU_LSB +: QU_W];
  wire [15:0] seqnum_byte_offset = cfg_q[`FSNE_CFG_OFF_LSB +: 16];

  // Frame classification; content of the frame plays no part
  wire seq_valid = (frm_class_i == `FSNE_CLASS_SEQ) && frm_dmac_ok_i;
  wire seq_ena = seq_valid && (initiator_role_enable || responder_role_enable);
  wire tx_req = seq_ena && frm_tx_i && initiator_role_enable;
  wire rx_rep = seq_ena && !frm_tx_i && initiator_role_enable;
  wire rx_req = seq_ena && !frm_tx_i && !initiator_role_enable;

  // Output stage; a held compensation high byte waits for its low byte
  assign out_valid_o = st_valid_q && !hold_q;
  assign out_data_o = st_data_q;
  assign out_last_o = st_last_q;
  assign in_ready_o = !pnd_valid_q && (hold_q || !st_valid_q || out_ready_i);
  wire fire = in_valid_i && in_ready_o;
  wire drain = out_valid_o && out_ready_i;

  // Record position from payload start
  wire in_pay = in_pay_start_i || pay_q;
  wire [15:0] pos_cur = in_pay_start_i ? 16'h0000 : pos_q;
  wire [16:0] rel = {1'b0, pos_cur} - {1'b0, seqnum_byte_offset};
  wire in_rec = in_pay && (pos_cur >= seqnum_byte_offset) && (rel < `FSNE_REC_LEN);
  wire [2:0] idx = rel[2:0];

  // Receive check of the completed sequence number
  wire [31:0] rx_num = {acc_q, in_data_i};
  wire [31:0] rx_expect = last_rx_seq_q + 32'h0000_0001;
  wire at_seq_end = fire && in_rec && (idx == `FSNE_REC_SEQ_LAST);
  wire chk_now = at_seq_end && (rx_rep || rx_req);
  wire mismatch = chk_now && (rx_num != rx_expect);
  wire err_cnt_inc = mismatch && rx_error_count_select;
  wire frame_err = err_q || mismatch;

  // Byte rewrite: number insertion and forward error flag
  reg [7:0] new_byte;
  always @* begin
    new_byte = in_data_i;
    if (in_rec && tx_req && idx <= `FSNE_REC_SEQ_LAST) begin
      new_byte = tx_seq_counter_q[(5'd24 - {idx[1:0], 3'b000}) +: 8];
    end else if (in_rec && rx_req && idx == `FSNE_REC_FLAG && err_q) begin
      new_byte = in_data_i | `FSNE_FLAG_BIT;
    end
  end

  // Compensation keeps the UDP checksum: c_new = c_old + old words - new words
  wire [15:0] c_old = {st_data_q, in_data_i};
  wire [15:0] sum_old = oc_add(oc_add(rec_old_q[47:32], rec_old_q[31:16]), rec_old_q[15:0]);
  wire [15:0] sum_new = oc_add(oc_add(~rec_new_q[47:32], ~rec_new_q[31:16]), ~rec_new_q[15:0]);
  wire [15:0] c_new = oc_add(c_old, oc_add(sum_old, sum_new));
  wire hold_set = fire && in_rec && idx == `FSNE_REC_CHK_HI && !in_last_i && checksum_fix_enable &&
    (mod_q || tx_req);

  // Stream path and per-frame state
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      st_valid_q <= 1'b0;
      st_data_q <= 8'h00;
      st_last_q <= 1'b0;
      pnd_valid_q <= 1'b0;
      pnd_data_q <= 8'h00;
      pnd_last_q <= 1'b0;
      hold_q <= 1'b0;
      pos_q <= 16'h0000;
      pay_q <= 1'b0;
      acc_q <= 24'h000000;
      rec_old_q <= 48'h0000_0000_0000;
      rec_new_q <= 48'h0000_0000_0000;
      err_q <= 1'b0;
      mod_q <= 1'b0;
    end else begin
      if (hold_q && fire) begin
        st_data_q <= c_new[15:8];
        pnd_data_q <= c_new[7:0];
        pnd_last_q <= in_last_i;
        pnd_valid_q <= 1'b1;
        hold_q <= 1'b0;
      end else if (drain || !st_valid_q) begin
        if (pnd_valid_q) begin
          st_data_q <= pnd_data_q;
          st_last_q <= pnd_last_q;
          pnd_valid_q <= 1'b0;
        end else if (fire) begin
          st_data_q <= new_byte;
          st_last_q <= in_last_i;
          st_valid_q <= 1'b1;
          hold_q <= hold_set;
        end else begin
          st_valid_q <= 1'b0;
        end
      end
      if (fire) begin
        pay_q <= in_pay && !in_last_i;
        pos_q <= (in_pay && pos_cur != 16'hffff) ? pos_cur + 16'h0001 : pos_cur;
        acc_q <= {acc_q[15:0], in_data_i};
        if (in_rec && idx < `FSNE_REC_CHK_HI) begin
          rec_old_q <= {rec_old_q[39:0], in_data_i};
          rec_new_q <= {rec_new_q[39:0], new_byte};
        end
        if (mismatch) begin
          err_q <= 1'b1;
          mod_q <= rx_req;
        end
        if (in_last_i) begin
          err_q <= 1'b0;
          mod_q <= 1'b0;
        end
      end
    end
  end

  // Per-frame verdict toward the forwarding logic
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      res_valid_o <= 1'b0;
      res_extract_o <= 1'b0;
      res_loop_o <= 1'b0;
      res_seq_err_o <= 1'b0;
      res_queue_o <= {QU_W{1'b0}};
    end else begin
      res_valid_o <= fire && in_last_i;
      res_seq_err_o <= (rx_rep || rx_req) && frame_err;
      res_queue_o <= reply_cpu_queue;
      res_loop_o <= rx_req && loop_enable;
      res_extract_o <= (rx_rep && seq_error_extract_enable && frame_err) ||
        (rx_rep && next_reply_extract) ||
        ((rx_rep || rx_req) && reply_copy_enable);
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  wire wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
  wire rd_go = s_axi_arvalid && s_axi_arready;
  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready = !w_full_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire wr_cfg = wr_go && awaddr_q == `FSNE_REG_CFG;
  wire wr_stk = wr_go && awaddr_q == `FSNE_REG_STICKY;
  wire [31:0] wr_mask = merge(32'h0000_0000, 32'hffff_ffff, wstrb_q);
  wire reply_done = fire && in_last_i && rx_rep;

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 6'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FSNE_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[5:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q <= `FSNE_REG_STICKY) ? `FSNE_RESP_OKAY : `FSNE_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Registers and counters; hardware sets win over software clears, software writes win on values
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      cfg_q <= `FSNE_CFG_RESET;
      tx_seq_counter_q <= 32'h0000_0000;
      last_rx_seq_q <= 32'h0000_0000;
      rx_reply_count_q <= 32'h0000_0000;
      rx_seq_error_count_q <= 32'h0000_0000;
      seq_rx_sticky_q <= 1'b0;
      seq_error_sticky_q <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_q <= merge(cfg_q, wdata_q, wstrb_q);
      end else if (reply_done && next_reply_extract) begin
        cfg_q[`FSNE_CFG_NXTEXT] <= 1'b0;
      end
      if (wr_go && awaddr_q == `FSNE_REG_TX_SEQ) begin
        tx_seq_counter_q <= merge(tx_seq_counter_q, wdata_q, wstrb_q);
      end else if (at_seq_end && tx_req) begin
        tx_seq_counter_q <= tx_seq_counter_q + 32'h0000_0001;
      end
      if (wr_go && awaddr_q == `FSNE_REG_LAST_RX) begin
        last_rx_seq_q <= merge(last_rx_seq_q, wdata_q, wstrb_q);
      end else if (chk_now) begin
        last_rx_seq_q <= rx_num;
      end
      if (wr_go && awaddr_q == `FSNE_REG_RX_CNT) begin
        rx_reply_count_q <= merge(rx_reply_count_q, wdata_q, wstrb_q);
      end else if (chk_now) begin
        rx_reply_count_q <= rx_reply_count_q + 32'h0000_0001;
      end
      if (wr_go && awaddr_q == `FSNE_REG_ERR_CNT) begin
        rx_seq_error_count_q <= merge(rx_seq_error_count_q, wdata_q, wstrb_q);
      end else if (err_cnt_inc) begin
        rx_seq_error_count_q <= rx_seq_error_count_q + 32'h0000_0001;
      end
      seq_rx_sticky_q <= chk_now ||
        (seq_rx_sticky_q && !(wr_stk && wdata_q[`FSNE_STK_RX] && wr_mask[`FSNE_STK_RX]));
      seq_error_sticky_q <= err_cnt_inc ||
        (seq_error_sticky_q && !(wr_stk && wdata_q[`FSNE_STK_ERR] && wr_mask[`FSNE_STK_ERR]));
    end
  end

  // Read path, answered one cycle after the address is taken
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `FSNE_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `FSNE_RESP_OKAY;
      case ({s_axi_araddr[5:2], 2'b00})
        `FSNE_REG_CFG: s_axi_rdata <= cfg_q;
        `FSNE_REG_TX_SEQ: s_axi_rdata <= tx_seq_counter_q;
        `FSNE_REG_LAST_RX: s_axi_rdata <= last_rx_seq_q;
        `FSNE_REG_RX_CNT: s_axi_rdata <= rx_reply_count_q;
        `FSNE_REG_ERR_CNT: s_axi_rdata <= rx_seq_error_count_q;
        `FSNE_REG_STICKY: s_axi_rdata <= {30'h0000_0000, seq_error_sticky_q, seq_rx_sticky_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `FSNE_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== verification/fsne_engine_asserts.sv ====
// Checker for the sequence number engine, bound to every instance.
// Assumes one clock domain with a synchronous active-high reset.
`default_nettype none
module fsne_engine_asserts (
  // Bus
  input wire logic core_clk_i, srst_i, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [5:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  // Stream and verdict
  input wire logic frm_tx_i, frm_dmac_ok_i, in_last_i, in_valid_i, in_ready_o, out_last_o, out_valid_o,
  input wire logic res_valid_o, res_extract_o, res_loop_o, res_seq_err_o,
  input wire logic [3:0] frm_class_i,
  input wire logic [7:0] in_data_i, out_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // Byte taken at the input
  wire acc = in_valid_i && in_ready_o;
  // Plain frames pass untouched, one cycle later
  a_plain_pass: assert property (acc && frm_class_i != 4'h5 |=> out_valid_o &&
    out_data_o == $past(in_data_i) && out_last_o == $past(in_last_i)) else $error("plain byte altered");
  // Invalid frames are never extracted, looped or flagged
  a_quiet_verdict: assert property (res_valid_o && ($past(frm_class_i) != 4'h5 || !$past(frm_dmac_ok_i)) |->
    !res_extract_o && !res_loop_o && !res_seq_err_o) else $error("invalid frame acted on");
  // Transmitted frames never loop
  a_tx_no_loop: assert property (res_valid_o && $past(frm_tx_i) |-> !res_loop_o)
    else $error("tx frame looped");
  // Verdict follows the last byte by one cycle
  a_verdict_time: assert property (acc && in_last_i |=> res_valid_o) else $error("verdict missing");
  // Bus answers and how long they stand
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 6'h17 |=>
    s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  // Main scenarios
  c_loop: cover property (res_valid_o && res_loop_o);
  c_err: cover property (res_valid_o && res_seq_err_o);
  c_ext: cover property (res_valid_o && res_extract_o);
endmodule
bind fsne_engine fsne_engine_asserts chk (.*);
`default_nettype wire

// ==== verification/fsne_peer.sv ====
// Far-end sink model: takes the engine's outgoing bytes as a peer port would.
// Assumes core clock timing; slow_i makes it refuse every other cycle.
`default_nettype none
module fsne_peer (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Stream from the engine
  input wire logic [7:0] d_i,
  input wire logic last_i,
  input wire logic valid_i,
  input wire logic slow_i,
  output var logic ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [$];
  initial ready_o = 1'b0;
  // Stalls force the engine to hold bytes, not just pass them
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= slow_i ? !ready_o : 1'b1;
      if (valid_i && ready_o) got.push_back(d_i);
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb_frame_sequence_number_engine.sv ====
// Directed bench for the sequence number engine: bus, frame and verdict checks.
// Assumes the engine, its checker and the sink model are compiled first.
`include "fsne_defines.vh"
`default_nettype none
module tb_frame_sequence_number_engine;
  timeunit 1ns;
  timeprecision 1ps;
  // Engine inputs, named as its ports
  // Response readies stay high: each answer is taken at the edge it is first sampled
  logic core_clk_i = 1'b0, srst_i = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, frm_tx_i = 1'b0, frm_dmac_ok_i = 1'b0, in_pay_start_i = 1'b0;
  logic in_last_i = 1'b0, in_valid_i = 1'b0, slow = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h0, s_axi_araddr = 6'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf, frm_class_i = 4'h0;
  logic [7:0] in_data_i = 8'h0;
  // Engine outputs
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, in_ready_o, out_last_o;
  wire logic out_valid_o, out_ready_i, res_valid_o, res_extract_o, res_loop_o, res_seq_err_o;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [7:0] out_data_o;
  wire logic [2:0] res_queue_o;
  // Bench state; vq holds queue, extract, error, loop of the last verdict
  logic [7:0] fb [16];
  logic [5:0] vq = 6'h0;
  int n_errors = 0, compares = 0, cyc = 0, k;

  fsne_engine uut (.*);
  fsne_peer peer (.core_clk_i(core_clk_i), .srst_i(srst_i), .d_i(out_data_o), .last_i(out_last_o),
    .valid_i(out_valid_o), .slow_i(slow), .ready_o(out_ready_i));

  // Clock, verdict capture and hang limit
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (res_valid_o === 1'b1) vq <= {res_queue_o, res_extract_o, res_seq_err_o, res_loop_o};
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task complete_run();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Write: address and data offered together, each held until its own ready edge
  task wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    logic da, dw;
    logic [1:0] r;
    da = 1'b0;
    dw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(da && dw)) begin
      @(posedge core_clk_i);
      if (!da && s_axi_awready === 1'b1) begin
        da = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dw && s_axi_wready === 1'b1) begin
        dw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk_i); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    chk({30'h0, r}, {30'h0, er});
  endtask

  // Read: address held until taken, data taken at the edge rvalid is seen
  task rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk_i); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    chk(d, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask

  // Filler frame with a record at off; reserved and compensation zeroed
  task mk(input int off, input logic [31:0] sq, input logic [7:0] fl);
    for (int i = 0; i < 16; i++) fb[i] = 8'h40 + 8'(i);
    {fb[off], fb[off+1], fb[off+2], fb[off+3]} = sq;
    fb[off+4] = fl;
    {fb[off+5], fb[off+6], fb[off+7]} = 24'h0;
  endtask

  // Sends fb as one frame, payload from byte 0, then waits for the drain
  task send(input logic tx, input logic [3:0] cls, input logic ok);
    peer.got.delete();
    frm_tx_i <= tx;
    frm_class_i <= cls;
    frm_dmac_ok_i <= ok;
    for (int i = 0; i < 16; i++) begin
      in_valid_i <= 1'b1;
      in_data_i <= fb[i];
      in_pay_start_i <= (i == 0);
      in_last_i <= (i == 15);
      do @(posedge core_clk_i); while (in_ready_o !== 1'b1);
    end
    in_valid_i <= 1'b0;
    for (k = 0; k < 200 && peer.got.size() < 16; k++) @(posedge core_clk_i);
    @(posedge core_clk_i);
  endtask

  function automatic logic [31:0] w4(input int o);
    return {peer.got[o], peer.got[o+1], peer.got[o+2], peer.got[o+3]};
  endfunction

  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk_i);
    srst_i <= 1'b0;
    rd(`FSNE_REG_CFG, `FSNE_CFG_RESET, 2'b00);
    rd(6'h20, 32'h0, 2'b10);
    wr(6'h24, 32'hffff_ffff, 2'b10);
    mk(2, 32'h1234_5678, 8'h80);
    send(1'b1, 4'h5, 1'b1);
    chk(w4(2), 32'h1234_5678);
    $display("test 1 done");
    wr(`FSNE_REG_CFG, 32'h0002_0001, 2'b00);
    wr(`FSNE_REG_TX_SEQ, 32'hffff_fffe, 2'b00);
    slow <= 1'b1;
    mk(2, 32'h0, 8'h00);
    send(1'b1, 4'h5, 1'b1);
    chk(w4(2), 32'hffff_fffe);
    chk({24'h0, peer.got[1]}, 32'h41);
    send(1'b1, 4'h5, 1'b1);
    chk(w4(2), 32'hffff_ffff);
    send(1'b1, 4'h5, 1'b0);
    chk(w4(2), 32'h0);
    rd(`FSNE_REG_TX_SEQ, 32'h0, 2'b00);
    $display("test 2 done");
    slow <= 1'b0;
    wr(`FSNE_REG_CFG, 32'h0002_0349, 2'b00);
    wr(`FSNE_REG_LAST_RX, 32'hffff_ffff, 2'b00);
    send(1'b0, 4'h5, 1'b1);
    chk({26'h0, vq}, 32'h1c);
    mk(2, 32'h5, 8'h00);
    send(1'b0, 4'h5, 1'b1);
    chk({26'h0, vq}, 32'h1e);
    mk(2, 32'h77, 8'h00);
    send(1'b0, 4'h3, 1'b1);
    send(1'b0, 4'h5, 1'b0);
    rd(`FSNE_REG_RX_CNT, 32'h2, 2'b00);
    rd(`FSNE_REG_ERR_CNT, 32'h1, 2'b00);
    rd(`FSNE_REG_LAST_RX, 32'h5, 2'b00);
    rd(`FSNE_REG_STICKY, 32'h3, 2'b00);
    wr(`FSNE_REG_STICKY, 32'h3, 2'b00);
    wr(`FSNE_REG_CFG, 32'h0002_0341, 2'b00);
    mk(2, 32'h14, 8'h00);
    send(1'b0, 4'h5, 1'b1);
    rd(`FSNE_REG_ERR_CNT, 32'h1, 2'b00);
    rd(`FSNE_REG_STICKY, 32'h1, 2'b00);
    $display("test 3 done");
    wr(`FSNE_REG_CFG, 32'h0002_0031, 2'b00);
    mk(2, 32'h15, 8'h00);
    send(1'b0, 4'h5, 1'b1);
    chk({31'h0, vq[2]}, 32'h1);
    mk(2, 32'h16, 8'h00);
    send(1'b0, 4'h5, 1'b1);
    chk({31'h0, vq[2]}, 32'h0);
    mk(2, 32'h1e, 8'h00);
    send(1'b0, 4'h5, 1'b1);
    chk({31'h0, vq[2]}, 32'h1);
    rd(`FSNE_REG_CFG, 32'h0002_0011, 2'b00);
    $display("test 4 done");
    slow <= 1'b1;
    wr(`FSNE_REG_CFG, 32'h0008_0086, 2'b00);
    wr(`FSNE_REG_LAST_RX, 32'h9, 2'b00);
    mk(8, 32'h7, 8'h00);
    send(1'b0, 4'h5, 1'b1);
    chk({24'h0, peer.got[12]}, 32'h80);
    chk({16'h0, peer.got[14], peer.got[15]}, 32'h7fff);
    chk({26'h0, vq}, 32'h03);
    mk(8, 32'h8, 8'h00);
    send(1'b0, 4'h5, 1'b1);
    chk({24'h0, peer.got[12]}, 32'h0);
    mk(8, 32'h0abc, 8'h00);
    send(1'b1, 4'h5, 1'b1);
    chk(w4(8), 32'h0abc);
    chk({31'h0, vq[0]}, 32'h0);
    $display("test 5 done");
    complete_run();
  end
endmodule
`default_nettype wire
